// ===== alc_ctrl.sv
// Converter control top: APB registers, triggers, result transfer and stop-mode handling.
`timescale 1ns/100ps
module alc_ctrl
    import alc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic light_stop,
    input wire logic deep_stop,
    input wire logic hw_trigger,
    input wire logic [9:0] analog_value,
    output logic conv_irq,
    output logic [4:0] channel_sel,
    output logic [15:0] pin_io_disable
);
    alc_cfg_t conversion_config;
    alc_trig_t trig_ctrl;
    alc_start_t start_ctrl;
    logic conv_complete_flag;
    logic [9:0] compare_value;
    logic [9:0] result;
    logic [7:0] pin_control_one;
    logic [7:0] pin_control_two;
    logic blocked;
    logic light_q;
    logic hw_q;
    logic conv_active_flag;
    logic conv_done;
    logic adck_tick;

    logic wr;
    logic rd;
    logic wr_start;
    logic cfg_change;
    logic stop_abort;
    logic run_ok;
    logic ten_bit;
    logic [9:0] data;
    logic [9:0] diff;
    logic cmp_ok;
    logic xfer;
    logic restart;
    logic sw_start;
    logic hw_start;
    logic conv_start;
    logic conv_abort;
    logic [7:0] read_mux;
    logic [10:0] stop_run_cycles;

    // Longest async conversion in system clocks, with slack: every tick at the slowest divider.
    localparam int STOP_RUN_MAX = (int'(ALC_TICKS_TEN) + int'(ALC_TICKS_LONG) + 2) * (int'(ALC_ASYNC_LAST) + 1) * 8;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = hit(addr, ALC_OFS_START) || hit(addr, ALC_OFS_TRIG) || hit(addr, ALC_OFS_RES_HIGH)
            || hit(addr, ALC_OFS_RES_LOW) || hit(addr, ALC_OFS_CMP_HIGH) || hit(addr, ALC_OFS_CMP_LOW)
            || hit(addr, ALC_OFS_CONFIG) || hit(addr, ALC_OFS_PIN_ONE) || hit(addr, ALC_OFS_PIN_TWO);
    endfunction : is_mapped

    // Writes and read side effects act only at the completing access edge.
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign rd = psel && penable && pready && !pwrite && !pslverr;
    assign wr_start = wr && hit(paddr, ALC_OFS_START);
    assign cfg_change = wr && (hit(paddr, ALC_OFS_TRIG) || hit(paddr, ALC_OFS_CONFIG)
        || hit(paddr, ALC_OFS_CMP_HIGH) || hit(paddr, ALC_OFS_CMP_LOW));

    assign stop_abort = light_stop && !light_q && (conversion_config.input_clock_select != ALC_CLK_ASYNC);
    assign run_ok = !light_stop || (conversion_config.input_clock_select == ALC_CLK_ASYNC);
    assign ten_bit = (conversion_config.resolution == ALC_MODE_TEN);

    always_comb begin
        data = ten_bit ? analog_value : {2'h0, analog_value[9:2]};
        diff = data - compare_value;
        if (!trig_ctrl.compare_enable) begin
            cmp_ok = 1'b1;
        end else if (trig_ctrl.compare_greater) begin
            cmp_ok = (data >= compare_value);
        end else begin
            cmp_ok = (data < compare_value);
        end
    end

    assign xfer = conv_done && cmp_ok && !blocked;
    assign restart = conv_done && run_ok && (start_ctrl.continuous_select || (blocked && cmp_ok));
    assign sw_start = wr_start && !trig_ctrl.trigger_select && (pwdata[4:0] != ALC_CH_OFF);
    assign hw_start = hw_trigger && !hw_q && trig_ctrl.trigger_select && run_ok
        && (start_ctrl.channel_select != ALC_CH_OFF);
    assign conv_start = !deep_stop && (sw_start || hw_start || restart);
    assign conv_abort = deep_stop || stop_abort || wr_start || cfg_change;

    alc_adck_gen u_adck_gen (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(conv_active_flag),
        .input_clock_select(conversion_config.input_clock_select),
        .clock_divider(conversion_config.clock_divider),
        .adck_tick(adck_tick)
    );

    alc_conv_seq u_conv_seq (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(conv_start),
        .abort(conv_abort),
        .adck_tick(adck_tick),
        .long_sample(conversion_config.long_sample_select),
        .ten_bit(ten_bit),
        .busy(conv_active_flag),
        .done(conv_done)
    );

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            light_q <= 1'b0;
            hw_q <= 1'b0;
        end else begin
            light_q <= light_stop;
            hw_q <= hw_trigger;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conversion_config <= ALC_RST_CONFIG;
            trig_ctrl <= ALC_RST_TRIG;
            start_ctrl <= ALC_RST_START;
            compare_value <= ALC_RST_WORD;
            pin_control_one <= ALC_RST_PIN;
            pin_control_two <= ALC_RST_PIN;
        end else if (deep_stop) begin
            conversion_config <= ALC_RST_CONFIG;
            trig_ctrl <= ALC_RST_TRIG;
            start_ctrl <= ALC_RST_START;
            compare_value <= ALC_RST_WORD;
            pin_control_one <= ALC_RST_PIN;
            pin_control_two <= ALC_RST_PIN;
        end else if (wr) begin
            if (hit(paddr, ALC_OFS_CONFIG)) begin
                conversion_config <= pwdata[7:0];
            end
            if (hit(paddr, ALC_OFS_TRIG)) begin
                trig_ctrl <= pwdata[6:4];
            end
            if (wr_start) begin
                start_ctrl <= pwdata[6:0];
            end
            if (hit(paddr, ALC_OFS_CMP_HIGH)) begin
                compare_value[9:8] <= pwdata[1:0];
            end
            if (hit(paddr, ALC_OFS_CMP_LOW)) begin
                compare_value[7:0] <= pwdata[7:0];
            end
            if (hit(paddr, ALC_OFS_PIN_ONE)) begin
                pin_control_one <= pwdata[7:0];
            end
            if (hit(paddr, ALC_OFS_PIN_TWO)) begin
                pin_control_two <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            result <= ALC_RST_WORD;
        end else if (deep_stop) begin
            result <= ALC_RST_WORD;
        end else if (xfer) begin
            result <= trig_ctrl.compare_enable ? diff : data;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conv_complete_flag <= 1'b0;
        end else if (deep_stop) begin
            conv_complete_flag <= 1'b0;
        end else if (xfer) begin
            conv_complete_flag <= 1'b1;
        end else if (wr_start || cfg_change || (rd && hit(paddr, ALC_OFS_RES_LOW))) begin
            conv_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            blocked <= 1'b0;
        end else if (deep_stop || (rd && hit(paddr, ALC_OFS_RES_LOW))) begin
            blocked <= 1'b0;
        end else if (rd && hit(paddr, ALC_OFS_RES_HIGH) && ten_bit) begin
            blocked <= 1'b1;
        end
    end

    // Outputs to the pins and the interrupt controller.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conv_irq <= 1'b0;
            channel_sel <= ALC_CH_OFF;
            pin_io_disable <= {ALC_RST_PIN, ALC_RST_PIN};
        end else begin
            conv_irq <= conv_complete_flag && start_ctrl.complete_irq_enable;
            channel_sel <= start_ctrl.channel_select;
            pin_io_disable <= {pin_control_two, pin_control_one};
        end
    end

    always_comb begin
        read_mux = 8'h00;
        case (paddr)
            ALC_OFS_START: read_mux = {conv_complete_flag, start_ctrl};
            ALC_OFS_TRIG: read_mux = {conv_active_flag, trig_ctrl, 4'h0};
            ALC_OFS_RES_HIGH: read_mux = {6'h00, result[9:8]};
            ALC_OFS_RES_LOW: read_mux = result[7:0];
            ALC_OFS_CMP_HIGH: read_mux = {6'h00, compare_value[9:8]};
            ALC_OFS_CMP_LOW: read_mux = compare_value[7:0];
            ALC_OFS_CONFIG: read_mux = conversion_config;
            ALC_OFS_PIN_ONE: read_mux = pin_control_one;
            ALC_OFS_PIN_TWO: read_mux = pin_control_two;
            default: read_mux = 8'h00;
        endcase
    end

    // Read data and the error answer are captured in the setup cycle, so pready adds no wait state.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !is_mapped(paddr);
            prdata <= {24'h00_0000, read_mux};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // A conversion may span far more cycles than a delay range allows, so a counter bounds it.
    // async run bound
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stop_run_cycles <= 11'h000;
        end else if (!(light_stop && run_ok && conv_active_flag) || conv_start) begin
            stop_run_cycles <= 11'h000;
        end else begin
            stop_run_cycles <= stop_run_cycles + 11'h001;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_start_write;
        wr_start && !trig_ctrl.trigger_select && !deep_stop;
    endsequence

    sequence s_stop_entry;
        light_stop && !light_q && !deep_stop;
    endsequence

    a_stop_abort_idle: assert property (s_stop_entry ##0 (conversion_config.input_clock_select != ALC_CLK_ASYNC)
        |=> !conv_active_flag [*2]) else $error("light stop did not abort");
    a_stop_result_hold: assert property ((s_stop_entry or $fell(light_stop)) ##0 (!xfer && !deep_stop)
        |=> $stable(result)) else $error("result changed at light stop edge");
    a_stop_stay_idle: assert property (light_stop && !run_ok && !conv_active_flag
        |=> !conv_active_flag) else $error("conversion started in aborting stop");
    a_async_keep_run: assert property (light_stop && run_ok && conv_active_flag && !conv_abort
        |=> conv_active_flag || conv_done) else $error("async conversion stopped early");
    a_async_run_bound: assert property (stop_run_cycles < 11'(STOP_RUN_MAX)) else $error("async conversion overran");
    a_complete_irq: assert property (xfer && !deep_stop |=> conv_complete_flag
        ##1 (conv_irq == $past(start_ctrl.complete_irq_enable))) else $error("completion not flagged");
    a_deep_clear_all: assert property (deep_stop |=> conversion_config == ALC_RST_CONFIG
        && start_ctrl == ALC_RST_START && !conv_active_flag) else $error("deep stop kept state");
    a_reserved_read: assert property (pready && hit(paddr, ALC_OFS_TRIG)
        |-> prdata[3:0] == 4'h0) else $error("reserved bits read nonzero");
    a_single_one_conv: assert property (xfer && !start_ctrl.continuous_select && !deep_stop
        |=> !conv_active_flag [*2]) else $error("single mode restarted");
    a_block_discard: assert property (blocked && conv_done && !conv_complete_flag && !deep_stop
        |=> !conv_complete_flag && $stable(result)) else $error("blocked result transferred");
    a_write_restart: assert property (s_start_write ##0 (pwdata[4:0] != ALC_CH_OFF)
        |=> conv_active_flag) else $error("start write did not start");
    a_write_off_idle: assert property (s_start_write ##0 (pwdata[4:0] == ALC_CH_OFF)
        |=> !conv_active_flag) else $error("all-ones channel started");
endmodule : alc_ctrl

// ===== alc_pkg.sv
// Register map, field layouts, reset values and timing constants of the converter control.
package alc_pkg;
    // Register byte offsets on the register bus.
    localparam logic [7:0] ALC_OFS_START = 8'h00;
    localparam logic [7:0] ALC_OFS_TRIG = 8'h04;
    localparam logic [7:0] ALC_OFS_RES_HIGH = 8'h08;
    localparam logic [7:0] ALC_OFS_RES_LOW = 8'h0c;
    localparam logic [7:0] ALC_OFS_CMP_HIGH = 8'h10;
    localparam logic [7:0] ALC_OFS_CMP_LOW = 8'h14;
    localparam logic [7:0] ALC_OFS_CONFIG = 8'h18;
    localparam logic [7:0] ALC_OFS_PIN_ONE = 8'h1c;
    localparam logic [7:0] ALC_OFS_PIN_TWO = 8'h20;

    // Conversion clock sources, the ten-bit resolution code and the channel-off code.
    localparam logic [1:0] ALC_CLK_BUS = 2'h0;
    localparam logic [1:0] ALC_CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] ALC_CLK_ALT = 2'h2;
    localparam logic [1:0] ALC_CLK_ASYNC = 2'h3;
    localparam logic [1:0] ALC_MODE_TEN = 2'h2;
    localparam logic [4:0] ALC_CH_OFF = 5'h1f;

    // Reset values.
    localparam logic [7:0] ALC_RST_CONFIG = 8'h00;
    localparam logic [2:0] ALC_RST_TRIG = 3'h0;
    localparam logic [6:0] ALC_RST_START = 7'h1f;
    localparam logic [9:0] ALC_RST_WORD = 10'h000;
    localparam logic [7:0] ALC_RST_PIN = 8'h00;

    // Conversion lengths in conversion clock ticks.
    localparam logic [5:0] ALC_TICKS_EIGHT = 6'h14;
    localparam logic [5:0] ALC_TICKS_TEN = 6'h17;
    localparam logic [5:0] ALC_TICKS_LONG = 6'h14;

    // Asynchronous conversion clock period, made from the system clock.
    localparam int ALC_SYS_PERIOD_NS = 50;
    localparam int ALC_ASYNC_PERIOD_NS = 250;
    localparam logic [2:0] ALC_ASYNC_LAST = 3'(ALC_ASYNC_PERIOD_NS / ALC_SYS_PERIOD_NS - 1);

    typedef struct packed {
        logic low_power_select;
        logic [1:0] clock_divider;
        logic long_sample_select;
        logic [1:0] resolution;
        logic [1:0] input_clock_select;
    } alc_cfg_t;

    typedef struct packed {
        logic complete_irq_enable;
        logic continuous_select;
        logic [4:0] channel_select;
    } alc_start_t;

    typedef struct packed {
        logic trigger_select;
        logic compare_enable;
        logic compare_greater;
    } alc_trig_t;
endpackage : alc_pkg

// ===== alc_adck_gen.sv
// Conversion clock enable: source select and power-of-two divider.
`timescale 1ns/100ps
module alc_adck_gen
    import alc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [1:0] input_clock_select,
    input wire logic [1:0] clock_divider,
    output logic adck_tick
);
    logic [2:0] src_count;
    logic [2:0] div_count;
    logic [2:0] src_last;
    logic [2:0] div_last;
    logic src_tick;

    always_comb begin
        case (input_clock_select)
            ALC_CLK_BUS_HALF: src_last = 3'h1;
            ALC_CLK_ASYNC: src_last = ALC_ASYNC_LAST;
            default: src_last = 3'h0;
        endcase
        div_last = 3'((4'h1 << clock_divider) - 4'h1);
        src_tick = (src_count == src_last);
    end

    // The counters rest while idle so every conversion started from idle begins on a fresh phase.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            src_count <= 3'h0;
        end else if (!run || src_tick) begin
            src_count <= 3'h0;
        end else begin
            src_count <= src_count + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_count <= 3'h0;
            adck_tick <= 1'b0;
        end else if (!run) begin
            div_count <= 3'h0;
            adck_tick <= 1'b0;
        end else begin
            adck_tick <= src_tick && (div_count == div_last);
            if (src_tick) begin
                div_count <= (div_count == div_last) ? 3'h0 : div_count + 3'h1;
            end
        end
    end
endmodule : alc_adck_gen

// ===== alc_conv_seq.sv
// Conversion sequencer: counts one conversion in conversion clock ticks.
`timescale 1ns/100ps
module alc_conv_seq
    import alc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic abort,
    input wire logic adck_tick,
    input wire logic long_sample,
    input wire logic ten_bit,
    output logic busy,
    output logic done
);
    logic [5:0] count;
    logic [5:0] target;

    // A start in the same cycle as an abort wins, so a write both ends and restarts.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            done <= 1'b0;
            count <= 6'h00;
            target <= ALC_TICKS_EIGHT;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                count <= 6'h00;
                target <= (ten_bit ? ALC_TICKS_TEN : ALC_TICKS_EIGHT) + (long_sample ? ALC_TICKS_LONG : 6'h00);
            end else if (abort) begin
                busy <= 1'b0;
            end else if (busy && adck_tick) begin
                if (count == target - 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + 6'h01;
                end
            end
        end
    end
endmodule : alc_conv_seq

// ===== alc_ctrl_test.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/100ps
module alc_ctrl_test;
    import alc_pkg::*;

    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic light_stop = 1'b0;
    logic deep_stop = 1'b0;
    logic hw_trigger = 1'b0;
    logic [9:0] analog_value = 10'h2a5;
    logic conv_irq;
    logic [4:0] channel_sel;
    logic [15:0] pin_io_disable;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    alc_ctrl dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .light_stop(light_stop), .deep_stop(deep_stop), .hw_trigger(hw_trigger),
        .analog_value(analog_value), .conv_irq(conv_irq), .channel_sel(channel_sel),
        .pin_io_disable(pin_io_disable));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // A hang is cut short here and reported through the same verdict.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // The master holds the request until pready is seen high; only then is read data taken.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task automatic wait_irq(input int n);
        int i;
        for (i = 0; i < n && conv_irq !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        chk({31'h0, conv_irq}, 32'h1);
    endtask : wait_irq

    task automatic idle_for(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle_for

    task automatic t_reset_values();
        rchk(ALC_OFS_CONFIG, 32'h0);
        rchk(ALC_OFS_TRIG, 32'h0);
        rchk(ALC_OFS_START, 32'h1f);
        rchk(ALC_OFS_PIN_ONE, 32'h0);
        chk({27'h0, channel_sel}, 32'h1f);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, conv_irq}, 32'h0);
    endtask : t_reset_values

    task automatic t_fields();
        apb(1'b1, ALC_OFS_CONFIG, 32'h98);
        rchk(ALC_OFS_CONFIG, 32'h98);
        apb(1'b1, ALC_OFS_TRIG, 32'h3c);
        rchk(ALC_OFS_TRIG, 32'h30);
        apb(1'b1, ALC_OFS_TRIG, 32'h0c);
        rchk(ALC_OFS_TRIG, 32'h00);
        apb(1'b1, ALC_OFS_PIN_ONE, 32'h02);
        idle_for(2);
        chk({16'h0, pin_io_disable}, 32'h0002);
    endtask : t_fields

    task automatic t_single();
        apb(1'b1, ALC_OFS_CONFIG, 32'h08);
        apb(1'b1, ALC_OFS_START, 32'h41);
        idle_for(2);
        chk({27'h0, channel_sel}, 32'h01);
        wait_irq(300);
        rchk(ALC_OFS_START, 32'hc1);
        rchk(ALC_OFS_RES_HIGH, 32'h2);
        rchk(ALC_OFS_RES_LOW, 32'ha5);
        idle_for(200);
        chk({31'h0, conv_irq}, 32'h0);
    endtask : t_single

    task automatic t_light_abort();
        apb(1'b1, ALC_OFS_START, 32'h41);
        analog_value <= 10'h13c;
        idle_for(3);
        light_stop <= 1'b1;
        idle_for(200);
        chk({31'h0, conv_irq}, 32'h0);
        light_stop <= 1'b0;
        idle_for(100);
        chk({31'h0, conv_irq}, 32'h0);
        rchk(ALC_OFS_TRIG, 32'h0);
        rchk(ALC_OFS_RES_HIGH, 32'h2);
        rchk(ALC_OFS_RES_LOW, 32'ha5);
    endtask : t_light_abort

    task automatic t_light_async();
        rchk(ALC_OFS_RES_LOW, 32'ha5);
        apb(1'b1, ALC_OFS_CONFIG, 32'h0b);
        apb(1'b1, ALC_OFS_TRIG, 32'h00);
        apb(1'b1, ALC_OFS_START, 32'h41);
        idle_for(2);
        light_stop <= 1'b1;
        wait_irq(600);
        rchk(ALC_OFS_RES_HIGH, 32'h1);
        rchk(ALC_OFS_RES_LOW, 32'h3c);
        apb(1'b1, ALC_OFS_TRIG, 32'h40);
        analog_value <= 10'h0f0;
        idle_for(20);
        chk({31'h0, conv_irq}, 32'h0);
        hw_trigger <= 1'b1;
        idle_for(2);
        hw_trigger <= 1'b0;
        wait_irq(600);
        rchk(ALC_OFS_RES_LOW, 32'hf0);
        light_stop <= 1'b0;
    endtask : t_light_async

    task automatic t_no_start();
        apb(1'b1, ALC_OFS_TRIG, 32'h00);
        apb(1'b1, ALC_OFS_START, 32'h5f);
        idle_for(600);
        chk({31'h0, conv_irq}, 32'h0);
        rchk(ALC_OFS_TRIG, 32'h0);
    endtask : t_no_start

    // A half-read result must hold off new results until the low byte is read.
    task automatic t_blocked();
        analog_value <= 10'h155;
        apb(1'b1, ALC_OFS_CONFIG, 32'h08);
        apb(1'b1, ALC_OFS_TRIG, 32'h00);
        apb(1'b1, ALC_OFS_START, 32'h41);
        wait_irq(300);
        rchk(ALC_OFS_RES_HIGH, 32'h1);
        analog_value <= 10'h0aa;
        apb(1'b1, ALC_OFS_START, 32'h41);
        idle_for(100);
        chk({31'h0, conv_irq}, 32'h0);
        rchk(ALC_OFS_RES_LOW, 32'h55);
        wait_irq(300);
        rchk(ALC_OFS_RES_HIGH, 32'h0);
        rchk(ALC_OFS_RES_LOW, 32'haa);
    endtask : t_blocked

    task automatic t_deep_stop();
        apb(1'b1, ALC_OFS_CONFIG, 32'h98);
        apb(1'b1, ALC_OFS_START, 32'h41);
        deep_stop <= 1'b1;
        idle_for(3);
        deep_stop <= 1'b0;
        rchk(ALC_OFS_CONFIG, 32'h0);
        rchk(ALC_OFS_START, 32'h1f);
        rchk(ALC_OFS_PIN_ONE, 32'h0);
        rchk(ALC_OFS_TRIG, 32'h0);
        chk({16'h0, pin_io_disable}, 32'h0);
    endtask : t_deep_stop

    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
        t_fields();
        t_single();
        t_light_abort();
        t_light_async();
        t_no_start();
        t_blocked();
        t_deep_stop();
        finish_test();
    end
endmodule : alc_ctrl_test
